// ==== verilog/slave_mailbox_port.sv ====
// slave mailbox port: master-facing byte port with handshake flags
`timescale 1ns/1ps
module slave_mailbox_port (
   input  wire logic                                clock,                  // 100 MHz system clock
   input  wire logic                                sys_rst,                // sync reset, high
   input  wire logic [7:0]                          port_byte_bus_in,       // byte bus sampled
   output logic      [7:0]                          port_byte_bus_out,      // byte bus driven
   output logic                                     port_byte_bus_oe_n,     // low while driving
   input  wire logic                                port_latch_input,       // ale or address line one
   input  wire logic                                port_select_n,          // chip select, low
   input  wire logic                                port_read_strobe_n,     // read strobe, low
   input  wire logic                                port_write_strobe_n,    // write strobe, low
   input  wire logic                                muxed_bus,              // 1 = multiplexed bus
   output logic                                     master_irq_out,         // master irq, high
   input  wire slave_mailbox_port_pkg::port_cfg_s     cfg,                    // slave configuration
   input  wire slave_mailbox_port_pkg::slave_access_s acc,                    // slave accesses
   output slave_mailbox_port_pkg::slave_view_s        view                    // slave-visible state
);
   // ****************************************
   // synchronization
   // ****************************************
   logic [2:0] strobe_s;
   logic       cs_n_s;
   logic       rd_n_s;
   logic       wr_n_s;
   logic       rd_n_d_reg;
   logic       wr_n_d_reg;
   logic       ale_d_reg;
   logic       ale_s1_reg;
   logic       ale_s2_reg;
   logic       lat_s1_reg;
   logic       lat_s2_reg;
   logic [7:0] bus_s1_reg;
   logic [7:0] bus_s2_reg;

   strobe_sync u_sync (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in ({port_select_n, port_read_strobe_n, port_write_strobe_n}),
      .sync_out (strobe_s)
   );
   assign cs_n_s = strobe_s[2];
   assign rd_n_s = strobe_s[1];
   assign wr_n_s = strobe_s[0];

   // data and latch input delayed to align with strobes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bus_s1_reg <= slave_mailbox_port_pkg::byte_rst;
         bus_s2_reg <= slave_mailbox_port_pkg::byte_rst;
         lat_s1_reg <= 1'b0;
         lat_s2_reg <= 1'b0;
         ale_s1_reg <= 1'b0;
         ale_s2_reg <= 1'b0;
      end else begin
         bus_s1_reg <= port_byte_bus_in;
         bus_s2_reg <= bus_s1_reg;
         lat_s1_reg <= port_latch_input;
         lat_s2_reg <= lat_s1_reg;
         ale_s1_reg <= port_latch_input;
         ale_s2_reg <= ale_s1_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_n_d_reg <= 1'b1;
         wr_n_d_reg <= 1'b1;
         ale_d_reg  <= 1'b0;
      end else begin
         rd_n_d_reg <= rd_n_s;
         wr_n_d_reg <= wr_n_s;
         ale_d_reg  <= ale_s2_reg;
      end
   end

   // ****************************************
   // register select
   // ****************************************
   logic reg_sel_reg;
   logic reg_select_internal;
   logic ale_fall;
   logic rd_done;
   logic wr_done;

   assign ale_fall = ale_d_reg & ~ale_s2_reg;
   assign rd_done  = ~rd_n_d_reg & rd_n_s & ~cs_n_s;
   assign wr_done  = ~wr_n_d_reg & wr_n_s & ~cs_n_s;

   // line one latched on ale fall
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_sel_reg <= 1'b0;
      end else if (ale_fall) begin
         reg_sel_reg <= bus_s2_reg[1];
      end
   end

   assign reg_select_internal = (muxed_bus | cfg.shared_mode) ? reg_sel_reg : lat_s2_reg;

   // ****************************************
   // mailbox registers and flags
   // ****************************************
   logic [7:0] data_input_reg;
   logic [7:0] data_output_reg;
   logic [7:0] command_reg;
   logic       ibe_reg;
   logic       obf_reg;
   logic       cbf_reg;
   logic       ibe_irq_reg;
   logic       obf_irq_reg;
   logic       m_wr_data;
   logic       m_wr_cmd;
   logic       m_rd_data;

   // writes to status land in command, except in shared mode
   assign m_wr_data = cfg.port_enable & wr_done & ~reg_select_internal;
   assign m_wr_cmd  = cfg.port_enable & wr_done & reg_select_internal;
   // reads of data input return output
   assign m_rd_data = cfg.port_enable & rd_done & ~reg_select_internal;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         data_input_reg <= slave_mailbox_port_pkg::byte_rst;
      end else if (m_wr_data) begin
         data_input_reg <= bus_s2_reg;
      end
   end

   // shared mode takes low address on ale
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         command_reg <= slave_mailbox_port_pkg::byte_rst;
      end else if (cfg.port_enable & cfg.shared_mode & ale_fall) begin
         command_reg <= bus_s2_reg;
      end else if (m_wr_cmd & ~cfg.shared_mode) begin
         command_reg <= bus_s2_reg;
      end
   end

   // slave fills output for next read
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         data_output_reg <= slave_mailbox_port_pkg::byte_rst;
      end else if (acc.wr_output) begin
         data_output_reg <= acc.wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ibe_reg <= 1'b1;
      end else if (m_wr_data) begin
         ibe_reg <= 1'b0;
      end else if (acc.rd_input) begin
         ibe_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         obf_reg <= 1'b0;
      end else if (acc.wr_output) begin
         obf_reg <= 1'b1;
      end else if (m_rd_data) begin
         obf_reg <= 1'b0;
      end
   end

   // only standard mode uses it; set beats clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cbf_reg <= 1'b0;
      end else if (m_wr_cmd & ~cfg.shared_mode) begin
         cbf_reg <= 1'b1;
      end else if (acc.clr_cmd_irq) begin
         cbf_reg <= 1'b0;
      end
   end

   // shared mode signals through buffer events
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ibe_irq_reg <= 1'b0;
         obf_irq_reg <= 1'b0;
      end else begin
         ibe_irq_reg <= cfg.shared_mode & m_wr_data;
         obf_irq_reg <= cfg.shared_mode & m_rd_data;
      end
   end

   // ****************************************
   // master interrupt and bus drive
   // ****************************************
   logic irq_next;

   always_comb begin
      irq_next = master_irq_out;
      if (m_wr_data | m_rd_data) begin
         irq_next = 1'b0;
      end else if ((acc.rd_input & cfg.irq_mask_ibe) | (acc.wr_output & cfg.irq_mask_obf)) begin
         irq_next = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         master_irq_out <= 1'b0;
      end else begin
         master_irq_out <= irq_next;
      end
   end

   logic [7:0] status_byte;
   // status: bit1 input empty, bit0 output full
   always_comb begin
      status_byte = slave_mailbox_port_pkg::byte_rst;
      status_byte[slave_mailbox_port_pkg::stat_ibe_bit] = ibe_reg;
      status_byte[slave_mailbox_port_pkg::stat_obf_bit] = obf_reg;
      status_byte[slave_mailbox_port_pkg::stat_cbf_bit] = ~cbf_reg;
   end

   // drive bus while select and read low
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         port_byte_bus_out  <= slave_mailbox_port_pkg::byte_rst;
         port_byte_bus_oe_n <= 1'b1;
      end else begin
         port_byte_bus_out  <= reg_select_internal ? status_byte : data_output_reg;
         port_byte_bus_oe_n <= ~(cfg.port_enable & ~port_select_n & ~port_read_strobe_n);
      end
   end

   // both flags set at command is error
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         view <= '0;
      end else begin
         view.cmd_irq     <= cbf_reg;
         view.ibe_irq     <= ibe_irq_reg;
         view.obf_irq     <= obf_irq_reg;
         view.error       <= cbf_reg & ibe_reg & obf_reg;
         view.status      <= status_byte;
         view.input_byte  <= data_input_reg;
         view.window_addr <= {cfg.base_byte, command_reg};
      end
   end
endmodule

// ==== shared/slave_mailbox_port_pkg.sv ====
// constants and carrier types for the byte-wide slave mailbox port
// Function
// - standard mode any bus, shared mode muxed only
// - select high: command/status, low: data registers
// - select from latched line one or address line
// - transfer completes on strobe rising edge
// - master data write clears empty, irq low
// - slave input read sets empty, irq high
// - slave output write sets full, irq high
// - master output read clears full, irq low
// - reads pipelined, data returned next read
// - base byte plus master byte addresses window
// - standard uses command irq, shared buffer irqs
// - master command write raises command irq
// - status bit1 input empty, bit0 output full
// - command irq with both flags set is error
// - drive bus on select and read low
// - data-input read returns output, status write hits command (refused in shared mode)
// - master irq output is active high
package slave_mailbox_port_pkg;
   localparam int          byte_w          = 8;
   localparam int          stat_ibe_bit    = 1;
   localparam int          stat_obf_bit    = 0;
   localparam int          stat_cbf_bit    = 2;
   localparam int          sync_stages     = 2;
   localparam logic [7:0]  byte_rst        = 8'h00;
   localparam logic [2:0]  strobe_rst      = 3'h7;

   // slave-side controls and accesses
   typedef struct packed {
      logic       port_enable;    // port active
      logic       shared_mode;    // shared memory mode
      logic       irq_mask_ibe;   // gate irq on input empty
      logic       irq_mask_obf;   // gate irq on output full
      logic [7:0] base_byte;      // upper window address
   } port_cfg_s;

   typedef struct packed {
      logic       rd_input;       // slave reads data input register
      logic       wr_output;      // slave writes data output register
      logic [7:0] wr_data;        // byte for data output register
      logic       clr_cmd_irq;    // slave acknowledges command irq
   } slave_access_s;

   typedef struct packed {
      logic       cmd_irq;        // command buffer full toward slave
      logic       ibe_irq;        // input buffer filled (shared mode)
      logic       obf_irq;        // output buffer emptied (shared mode)
      logic       error;          // command with both flags set
      logic [7:0] status;         // status register as slave sees it
      logic [7:0] input_byte;     // data input register
      logic [15:0] window_addr;   // base plus command byte
   } slave_view_s;
endpackage

// ==== verilog/strobe_sync.sv ====
// two-stage synchronizer for the master strobes
`timescale 1ns/1ps
module strobe_sync (
   input  wire logic       clock,    // system clock
   input  wire logic       sys_rst,  // sync reset, high
   input  wire logic [2:0] async_in, // raw strobes
   output logic      [2:0] sync_out  // synchronized strobes
);
   logic [2:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_reg <= slave_mailbox_port_pkg::strobe_rst;
         sync_out <= slave_mailbox_port_pkg::strobe_rst;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ==== verification/slave_mailbox_port_properties.sv ====
// concurrent checks on the slave mailbox port pins
`timescale 1ns/1ps
module slave_mailbox_port_properties (
   input wire logic                              clock,               // clock
   input wire logic                              sys_rst,             // sync reset
   input wire logic [7:0]                        port_byte_bus_in,    // bus in
   input wire logic [7:0]                        port_byte_bus_out,   // bus out
   input wire logic                              port_byte_bus_oe_n,  // bus enable
   input wire logic                              port_latch_input,    // latch
   input wire logic                              port_select_n,       // select
   input wire logic                              port_read_strobe_n,  // read
   input wire logic                              port_write_strobe_n, // write
   input wire logic                              muxed_bus,           // muxed
   input wire logic                              master_irq_out,      // master irq
   input wire slave_mailbox_port_pkg::port_cfg_s     cfg,                 // config
   input wire slave_mailbox_port_pkg::slave_access_s acc,                 // slave access
   input wire slave_mailbox_port_pkg::slave_view_s   view                 // slave view
);
   // ****************************************
   // one clock domain
   // ****************************************
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   oe_follows_read_a: assert property (
      !$past(sys_rst) |-> port_byte_bus_oe_n == !$past(!port_select_n && !port_read_strobe_n && cfg.port_enable))
      else $error("bus enable does not follow select and read");
   write_drops_irq_a: assert property (
      $fell(view.status[1]) |-> !master_irq_out) else $error("irq high after master data write");
   slave_read_sets_a: assert property (
      acc.rd_input && cfg.irq_mask_ibe && cfg.port_enable |-> ##2 master_irq_out && view.status[1])
      else $error("slave read did not set empty flag and irq");
   slave_write_sets_a: assert property (
      acc.wr_output && cfg.irq_mask_obf && cfg.port_enable |-> ##2 master_irq_out && view.status[0])
      else $error("slave write did not set full flag and irq");
   read_drops_irq_a: assert property (
      $fell(view.status[0]) |-> !master_irq_out) else $error("irq high after master data read");
   error_flag_a: assert property (
      view.error == (!view.status[2] && view.status[1] && view.status[0])) else $error("error flag wrong");
   window_base_a: assert property (
      !$past(sys_rst) |-> view.window_addr[15:8] == $past(cfg.base_byte)) else $error("window base wrong");
   cmd_irq_status_a: assert property (
      view.cmd_irq |-> !view.status[2]) else $error("command irq without full command buffer");
   shared_write_pulse_a: assert property (
      view.ibe_irq |-> !view.status[1] && cfg.shared_mode) else $error("shared write irq without data write");
endmodule
bind slave_mailbox_port slave_mailbox_port_properties u_slave_mailbox_port_properties (
   .clock(clock), .sys_rst(sys_rst), .port_byte_bus_in(port_byte_bus_in),
   .port_byte_bus_out(port_byte_bus_out), .port_byte_bus_oe_n(port_byte_bus_oe_n),
   .port_latch_input(port_latch_input), .port_select_n(port_select_n),
   .port_read_strobe_n(port_read_strobe_n), .port_write_strobe_n(port_write_strobe_n),
   .muxed_bus(muxed_bus), .master_irq_out(master_irq_out), .cfg(cfg), .acc(acc), .view(view));

// ==== verification/master_model.sv ====
// master processor model driving the port pins
`timescale 1ns/1ps
module master_model (
   input  wire logic       clock,  // clock
   input  wire logic       muxed,  // 1 = multiplexed bus
   input  wire logic [7:0] bus,    // resolved byte bus
   output logic      [7:0] drv,    // byte driven
   output logic            drv_en, // driving the bus
   output logic            latch,  // ale or address line one
   output logic            cs_n,   // select
   output logic            rd_n,   // read strobe
   output logic            wr_n    // write strobe
);
   // ****************************************
   // one bus cycle
   // ****************************************
   initial begin
      drv = 8'h00; drv_en = 1'b0; latch = 1'b0; cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1;
   end
   task automatic xfer(input logic wr, input logic sel, input logic [7:0] d, output logic [7:0] q);
      @(posedge clock); #1;
      // select on line one or latch
      latch = muxed | sel;
      drv = muxed ? {6'h00, sel, 1'b0} : d;
      drv_en = muxed | wr;
      cs_n = 1'b0;
      repeat (3) @(posedge clock); #1;
      latch = sel & !muxed;
      repeat (3) @(posedge clock); #1;
      drv = d; drv_en = wr; wr_n = !wr; rd_n = wr;
      repeat (4) @(posedge clock); #1;
      q = bus;
      wr_n = 1'b1; rd_n = 1'b1;
      // data held past the rise for the slave's synchronizer
      repeat (4) @(posedge clock); #1;
      cs_n = 1'b1; drv_en = 1'b0;
      repeat (6) @(posedge clock);
   endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the slave mailbox port
`timescale 1ns/1ps
module tb;
   logic                                  clock, sys_rst, muxed_bus, oe_n, drv_en, latch, cs_n, rd_n, wr_n, irq;
   logic [7:0]                            bus_out, bus, drv, q, k;
   slave_mailbox_port_pkg::port_cfg_s     cfg;
   slave_mailbox_port_pkg::slave_access_s acc;
   slave_mailbox_port_pkg::slave_view_s   view;
   int                                    fails = 0, samples_checked = 0, cycles = 0;
   // tri-state bus with pull-up
   assign bus = !oe_n ? bus_out : (drv_en ? drv : 8'hff);
   slave_mailbox_port u_slave_mailbox_port (.clock(clock), .sys_rst(sys_rst), .port_byte_bus_in(bus),
      .port_byte_bus_out(bus_out), .port_byte_bus_oe_n(oe_n), .port_latch_input(latch), .port_select_n(cs_n),
      .port_read_strobe_n(rd_n), .port_write_strobe_n(wr_n), .muxed_bus(muxed_bus), .master_irq_out(irq),
      .cfg(cfg), .acc(acc), .view(view));
   master_model u_master_model (.clock(clock), .muxed(muxed_bus), .bus(bus), .drv(drv), .drv_en(drv_en),
      .latch(latch), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic sl(input logic r, input logic w, input logic c, input logic [7:0] d);
      @(posedge clock); #1;
      acc = '{r, w, d, c};
      @(posedge clock); #1;
      acc = '0;
      repeat (3) @(posedge clock); #1;
   endtask
   task automatic print_verdict;
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // hang guard, far beyond the sequence length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         print_verdict;
      end
   end
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      cfg = '{1'b1, 1'b0, 1'b1, 1'b1, 8'h04}; acc = '0; muxed_bus = 1'b0; sys_rst = 1'b1; k = 8'h00;
      repeat (4) @(posedge clock); #1;
      sys_rst = 1'b0;
      repeat (3) @(posedge clock); #1;
      chk("status", 8'h06, view.status);
      chk("irq", 1'b0, irq);
      for (int m = 0; m < 2; m++) begin
         k = m[7:0]; muxed_bus = m[0];
         sl(1'b1, 1'b0, 1'b0, 8'h00); chk("irq", 1'b1, irq);
         u_master_model.xfer(1'b1, 1'b0, 8'ha5 + k, q);
         chk("input_byte", 8'ha5 + k, view.input_byte);
         chk("status", 8'h04, view.status);
         chk("irq", 1'b0, irq);
         sl(1'b1, 1'b0, 1'b0, 8'h00); chk("status", 8'h06, view.status);
         chk("irq", 1'b1, irq);
         u_master_model.xfer(1'b1, 1'b1, 8'h3c + k, q);
         chk("window", {8'h04, 8'h3c + k}, view.window_addr);
         chk("cmd_irq", 1'b1, view.cmd_irq);
         chk("status", 8'h02, view.status);
         sl(1'b0, 1'b0, 1'b1, 8'h00); sl(1'b0, 1'b1, 1'b0, 8'h5a + k);
         chk("status", 8'h07, view.status);
         chk("irq", 1'b1, irq);
         u_master_model.xfer(1'b1, 1'b1, 8'h11, q); chk("error", 1'b1, view.error);
         sl(1'b0, 1'b0, 1'b1, 8'h00); chk("error", 1'b0, view.error);
         u_master_model.xfer(1'b0, 1'b1, 8'h00, q); chk("status_read", 8'h07, q);
         u_master_model.xfer(1'b0, 1'b0, 8'h00, q); chk("data_read", 8'h5a + k, q);
         chk("status", 8'h06, view.status);
         chk("irq", 1'b0, irq);
      end
      cfg.port_enable = 1'b0;
      u_master_model.xfer(1'b1, 1'b0, 8'hff, q); chk("input_byte", 8'ha6, view.input_byte);
      chk("status", 8'h06, view.status);
      // shared mode: low address from the ale phase, command writes refused
      cfg.port_enable = 1'b1; cfg.shared_mode = 1'b1; muxed_bus = 1'b1;
      u_master_model.xfer(1'b1, 1'b0, 8'h77, q); chk("input_byte", 8'h77, view.input_byte);
      chk("window", 16'h0400, view.window_addr);
      chk("status", 8'h04, view.status);
      u_master_model.xfer(1'b1, 1'b1, 8'h99, q); chk("cmd_irq", 1'b0, view.cmd_irq);
      chk("window", 16'h0402, view.window_addr);
      print_verdict;
   end
endmodule
